//--- src/subcode_serial_interface.sv
// Overview of operation
// R1 - 13-bit segment base locates fifo region
// R2 - fifos occupy contiguous segments from base
// R3 - subcode and audio fifos live in region
// R4 - serial subcode assembled into Q-W bytes
// R5 - subcode block aligned to current data block
// R6 - subcode sync triggers the block copy engine
// R7 - corrector computes crc syndrome, cpu corrects
// R8 - two 512-byte fifos, transmit and receive
// R9 - no fifo level interrupts; copy engine services
// R10 - interrupt on sync at unexpected position
// R11 - resynchronise reception after sync loss
// R12 - read clock polarity selectable, input word-select reference
// R13 - transmit timed by output word-select
// R14 - reception works with 2x/4x oversampling
// R15 - one read clock and sync pin shared
// R16 - tx bit 4 sets three-wire P level
// R17 - tx bit 2 enables transmit
// R18 - tx bit 0 selects transmit format
// R19 - software picks four-wire for digital output
// R20 - digital output subcode only in data mode
// R21 - three-wire frame-syncs recorder before data
// R22 - rx bits: enable, clock invert, format
// R23 - 9-bit read and write pointers
// R24 - fifo pointers wrap at 512
`timescale 1ns/10ps
`default_nettype none
module subcode_serial_interface (
  // system clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // serial link bit clock
  input  wire logic        link_clk,
  // sub-cpu register port
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  // serial subcode pins
  input  wire logic        input_word_select,
  input  wire logic        output_word_select,
  input  wire logic        subcode_data_in,
  output logic             subcode_data_out,
  output logic             subcode_read_clock,
  input  wire logic        subcode_frame_sync_i,
  output logic             subcode_frame_sync_o,
  output logic             subcode_frame_sync_oe,
  // block copy engine
  output logic             copy_trigger,
  output logic      [23:0] copy_src_addr,
  input  wire logic        rx_pop,
  output logic      [7:0]  rx_pop_data,
  output logic             rx_empty,
  input  wire logic        tx_push,
  input  wire logic [7:0]  tx_push_data,
  output logic             tx_full,
  input  wire logic        copy_done,
  output logic             crc_syndrome_req,
  // decoder and digital audio output
  input  wire logic        disc_data_mode,
  output logic             unexpected_sync_irq,
  output logic             dao_sub_valid,
  output logic      [7:0]  dao_sub_data,
  output logic      [23:0] audio_fifo_addr
);
  // ---------------- system domain state
  logic [7:0]  tx_ctrl_q;
  logic [7:0]  rx_ctrl_q;
  logic [7:0]  base_h_q;
  logic [7:0]  base_l_q;
  logic [7:0]  cpu_rdata_q;
  logic [12:0] base;
  logic [1:0]  tog_s;
  logic [1:0]  tog_seen_q;
  logic        rx_evt;
  logic        req_evt;
  logic        locked_q;
  logic [6:0]  sym_q;
  logic        irq_q;
  logic        trig_q;
  logic [8:0]  bptr_w_q;
  logic [8:0]  bptr_r_q;
  logic [23:0] src_q;
  logic        rx_wr;
  logic        tx_rd;
  logic        pend_q;
  logic        popped_q;
  logic [7:0]  tx_byte_q;
  logic        ack_q;
  logic        dao_valid_q;
  logic [7:0]  dao_data_q;
  logic        crc_req_q;
  logic [8:0]  rx_wr_ptr;
  logic [8:0]  rx_rd_ptr;
  logic [8:0]  tx_wr_ptr;
  logic [8:0]  tx_rd_ptr;
  logic [7:0]  tx_rd_data;
  logic        tx_empty;
  logic        rx_full;
  // ---------------- link domain state
  logic        lrst_n;
  logic [7:0]  cfg_s;
  logic [4:0]  pin_s;
  logic        rx_mode;
  logic        tx_mode;
  logic        fmt_qw;
  logic        ref_lvl;
  logic        ref_q;
  logic        rise;
  logic        slot;
  logic [2:0]  div_cnt_q;
  subcode_pkg::link_st_e st_q;
  logic        rck_q;
  logic        sample;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  rx_sh_q;
  logic [7:0]  rx_nxt;
  logic [7:0]  tx_sh_q;
  logic [7:0]  tx_load;
  logic        sync_cap_q;
  logic [8:0]  rx_hold_q;
  logic        rx_tog_q;
  logic        tx_req_q;
  logic        first_q;
  logic [6:0]  tx_sym_q;
  logic [6:0]  tx_sym_n;
  logic        aligned_q;
  logic        aligned_n;
  logic        subcode_frame_sync_o_q;
  logic        subcode_frame_sync_oe_q;
  logic        ack_seen_q;
  logic [7:0]  tx_next_q;

  assign base = {base_h_q[4:0], base_l_q}; // R1

  // sub-cpu writes; reserved bits are held at zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_ctrl_q <= subcode_pkg::TX_CTRL_RST;
      rx_ctrl_q <= subcode_pkg::RX_CTRL_RST;
      base_h_q  <= subcode_pkg::BASE_RST;
      base_l_q  <= subcode_pkg::BASE_RST;
    end else if (cpu_wr) begin
      case (cpu_addr)
        subcode_pkg::A_TX_CTRL: tx_ctrl_q <= cpu_wdata & subcode_pkg::TX_CTRL_MASK; // R16 R17 R18
        subcode_pkg::A_RX_CTRL: rx_ctrl_q <= cpu_wdata & subcode_pkg::RX_CTRL_MASK; // R22
        subcode_pkg::A_BASE_H:  base_h_q  <= cpu_wdata & subcode_pkg::BASE_H_MASK; // R1
        subcode_pkg::A_BASE_L:  base_l_q  <= cpu_wdata; // R1
        default: ;
      endcase
    end
  end

  // sub-cpu reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_rdata_q <= 8'h00;
    end else if (cpu_rd) begin
      case (cpu_addr)
        subcode_pkg::A_TX_CTRL:  cpu_rdata_q <= tx_ctrl_q;
        subcode_pkg::A_RX_CTRL:  cpu_rdata_q <= rx_ctrl_q;
        subcode_pkg::A_BASE_H:   cpu_rdata_q <= base_h_q;
        subcode_pkg::A_BASE_L:   cpu_rdata_q <= base_l_q;
        subcode_pkg::A_PTR_R_H:  cpu_rdata_q <= {7'h00, tx_rd_ptr[8]}; // R23
        subcode_pkg::A_PTR_R_L:  cpu_rdata_q <= tx_rd_ptr[7:0];
        subcode_pkg::A_BPTR_R_H: cpu_rdata_q <= {7'h00, bptr_r_q[8]};
        subcode_pkg::A_BPTR_R_L: cpu_rdata_q <= bptr_r_q[7:0];
        subcode_pkg::A_PTR_W_H:  cpu_rdata_q <= {7'h00, rx_wr_ptr[8]}; // R23
        subcode_pkg::A_PTR_W_L:  cpu_rdata_q <= rx_wr_ptr[7:0];
        subcode_pkg::A_BPTR_W_H: cpu_rdata_q <= {7'h00, bptr_w_q[8]};
        subcode_pkg::A_BPTR_W_L: cpu_rdata_q <= bptr_w_q[7:0];
        default:                 cpu_rdata_q <= 8'h00;
      endcase
    end
  end

  // two on-chip fifos; their rx_empty and tx_full flags go only to the copy engine, never to an interrupt
  subcode_byte_fifo u_rx_fifo ( // R8 R9
    .clk     (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (rx_wr),
    .wr_data (rx_hold_q[7:0]),
    .full    (rx_full),
    .rd_en   (rx_pop),
    .rd_data (rx_pop_data),
    .empty   (rx_empty),
    .wr_ptr  (rx_wr_ptr),
    .rd_ptr  (rx_rd_ptr)
  );
  subcode_byte_fifo u_tx_fifo ( // R8 R9
    .clk     (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (tx_push),
    .wr_data (tx_push_data),
    .full    (tx_full),
    .rd_en   (tx_rd),
    .rd_data (tx_rd_data),
    .empty   (tx_empty),
    .wr_ptr  (tx_wr_ptr),
    .rd_ptr  (tx_rd_ptr)
  );

  // link toggles into the system domain
  subcode_sync2 #(.W(2)) u_sync_tog (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     ({tx_req_q, rx_tog_q}),
    .q     (tog_s)
  );
  always_ff @(posedge sys_clk) begin
    if (!rst_n) tog_seen_q <= 2'h0;
    else        tog_seen_q <= tog_s;
  end
  assign rx_evt  = tog_s[0] ^ tog_seen_q[0];
  assign req_evt = tog_s[1] ^ tog_seen_q[1];
  // bytes before lock, or a missing sync slot, are not stored
  assign rx_wr   = rx_evt && (rx_hold_q[8] || (locked_q && sym_q != subcode_pkg::LAST_SYM)); // R5 R11

  // frame lock, misplaced sync and copy trigger
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      locked_q <= 1'b0;
      sym_q    <= subcode_pkg::LAST_SYM;
      irq_q    <= 1'b0;
      trig_q   <= 1'b0;
      bptr_w_q <= 9'h000;
      src_q    <= 24'h000000;
    end else begin
      irq_q  <= 1'b0;
      trig_q <= 1'b0;
      if (!rx_ctrl_q[subcode_pkg::RX_ENA]) begin
        locked_q <= 1'b0;
      end else if (rx_evt && rx_hold_q[8]) begin
        irq_q    <= locked_q && sym_q != subcode_pkg::LAST_SYM; // R10
        locked_q <= 1'b1; // R11
        sym_q    <= 7'h00;
        bptr_w_q <= rx_wr_ptr; // R5
        trig_q   <= 1'b1; // R6
        src_q    <= subcode_pkg::region_addr(base, subcode_pkg::RX_FIFO_OFS + {2'b00, rx_wr_ptr}); // R2 R3
      end else if (rx_evt) begin
        if (sym_q == subcode_pkg::LAST_SYM) locked_q <= 1'b0; // R11
        else                                sym_q    <= sym_q + 7'h01;
      end
    end
  end

  // serve link byte requests from the tx fifo; an empty fifo sends zero
  assign tx_rd = req_evt && !tx_empty;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend_q      <= 1'b0;
      popped_q    <= 1'b0;
      bptr_r_q    <= 9'h000;
      tx_byte_q   <= 8'h00;
      ack_q       <= 1'b0;
      dao_valid_q <= 1'b0;
      dao_data_q  <= 8'h00;
    end else begin
      pend_q      <= req_evt;
      popped_q    <= tx_rd;
      dao_valid_q <= 1'b0;
      if (req_evt && first_q) bptr_r_q <= tx_rd_ptr;
      if (pend_q) begin
        tx_byte_q   <= popped_q ? tx_rd_data : 8'h00;
        ack_q       <= ~ack_q;
        // digital output only carries the four-wire stream in data mode
        dao_valid_q <= disc_data_mode && tx_ctrl_q[subcode_pkg::TX_FMT]; // R19 R20
        dao_data_q  <= popped_q ? tx_rd_data : 8'h00;
      end
    end
  end

  // syndrome request once the copy engine has deposited the frame
  always_ff @(posedge sys_clk) begin
    if (!rst_n) crc_req_q <= 1'b0;
    else        crc_req_q <= copy_done; // R7
  end

  assign cpu_rdata           = cpu_rdata_q;
  assign copy_trigger        = trig_q;
  assign copy_src_addr       = src_q;
  assign unexpected_sync_irq = irq_q;
  assign crc_syndrome_req    = crc_req_q;
  assign dao_sub_valid       = dao_valid_q;
  assign dao_sub_data        = dao_data_q;
  assign audio_fifo_addr     = subcode_pkg::region_addr(base, subcode_pkg::AUDIO_FIFO_OFS); // R3

  // ---------------- link domain
  subcode_sync2 #(.W(1)) u_sync_rst (
    .clk   (link_clk),
    .rst_n (1'b1),
    .d     (rst_n),
    .q     (lrst_n)
  );
  // control bits are quasi-static, so per-bit resync is safe
  subcode_sync2 #(.W(8)) u_sync_cfg (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .d     ({tx_ctrl_q[subcode_pkg::TX_PBIT], tx_ctrl_q[subcode_pkg::TX_FMT], tx_ctrl_q[subcode_pkg::TX_ENA],
             rx_ctrl_q[4:3], rx_ctrl_q[subcode_pkg::RX_ENA], rx_ctrl_q[subcode_pkg::RX_INV],
             rx_ctrl_q[subcode_pkg::RX_FMT]}),
    .q     (cfg_s)
  );
  subcode_sync2 #(.W(5)) u_sync_pin (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .d     ({ack_q, subcode_data_in, subcode_frame_sync_i, output_word_select, input_word_select}),
    .q     (pin_s)
  );

  // receive owns the shared pins when both sides are enabled
  assign rx_mode = cfg_s[2]; // R22
  assign tx_mode = cfg_s[5] && !cfg_s[2]; // R15 R17
  assign fmt_qw  = rx_mode ? cfg_s[0] : cfg_s[6]; // R18 R22
  assign ref_lvl = rx_mode ? pin_s[0] : pin_s[1]; // R12 R13
  assign rise    = ref_lvl && !ref_q && (rx_mode || tx_mode);
  assign slot    = rise && div_cnt_q == subcode_pkg::div_last(cfg_s[4:3]); // R14
  assign sample  = st_q == subcode_pkg::LS_SHIFT && rck_q != cfg_s[1];
  assign rx_nxt  = {rx_sh_q[6:0], pin_s[3]}; // R4
  assign tx_sym_n  = tx_sym_q == subcode_pkg::LAST_SYM ? 7'h00 : tx_sym_q + 7'h01;
  assign aligned_n = tx_mode && (aligned_q || tx_sym_n == 7'h00); // R21
  // P is driven high when the control bit is clear
  assign tx_load = !aligned_n ? {!cfg_s[7], 7'h00}
                 : cfg_s[6] ? {tx_next_q[6:0], 1'b0} : {!cfg_s[7], tx_next_q[6:0]}; // R16 R18 R21

  // word-select edges divided down to one symbol slot
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      ref_q     <= 1'b0;
      div_cnt_q <= 3'h0;
    end else begin
      ref_q <= ref_lvl;
      if (rise) div_cnt_q <= slot ? 3'h0 : div_cnt_q + 3'h1; // R14
    end
  end

  // bit engine: read clock idles at the selected polarity
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      st_q       <= subcode_pkg::LS_IDLE;
      rck_q      <= 1'b0;
      bit_cnt_q  <= 4'h0;
      rx_sh_q    <= 8'h00;
      tx_sh_q    <= 8'h00;
      sync_cap_q <= 1'b0;
    end else begin
      unique case (st_q)
        subcode_pkg::LS_IDLE: begin
          rck_q <= cfg_s[1]; // R12
          if (slot) begin
            st_q       <= subcode_pkg::LS_SHIFT;
            bit_cnt_q  <= fmt_qw ? subcode_pkg::BITS_QW : subcode_pkg::BITS_3W;
            sync_cap_q <= pin_s[2];
            tx_sh_q    <= tx_load;
          end
        end
        subcode_pkg::LS_SHIFT: begin
          rck_q <= !rck_q;
          if (sample) begin
            rx_sh_q   <= rx_nxt; // R4
            tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q - 4'h1;
            if (bit_cnt_q == 4'h1) st_q <= subcode_pkg::LS_IDLE;
          end
        end
      endcase
    end
  end

  // finished receive byte is held while its toggle crosses
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      rx_hold_q <= 9'h000;
      rx_tog_q  <= 1'b0;
    end else if (sample && bit_cnt_q == 4'h1 && rx_mode) begin
      rx_hold_q <= {sync_cap_q, fmt_qw ? {1'b0, rx_nxt[6:0]} : rx_nxt}; // R4
      rx_tog_q  <= !rx_tog_q;
    end
  end

  // transmit framing: sync out on symbol 0, byte requests once aligned
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      tx_sym_q  <= subcode_pkg::LAST_SYM;
      aligned_q <= 1'b0;
      subcode_frame_sync_o_q  <= 1'b0;
      subcode_frame_sync_oe_q <= 1'b0;
      tx_req_q  <= 1'b0;
      first_q   <= 1'b0;
    end else begin
      subcode_frame_sync_oe_q <= tx_mode; // R15
      if (!tx_mode) begin
        tx_sym_q  <= subcode_pkg::LAST_SYM;
        aligned_q <= 1'b0;
        subcode_frame_sync_o_q  <= 1'b0;
      end else if (slot) begin
        tx_sym_q  <= tx_sym_n;
        aligned_q <= aligned_n; // R21
        subcode_frame_sync_o_q  <= tx_sym_n == 7'h00;
        if (aligned_n) begin
          tx_req_q <= !tx_req_q;
          first_q  <= tx_sym_n == subcode_pkg::LAST_SYM;
        end
      end
    end
  end

  // next transmit byte taken when the acknowledge toggle arrives
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      ack_seen_q <= 1'b0;
      tx_next_q  <= 8'h00;
    end else begin
      ack_seen_q <= pin_s[4];
      if (pin_s[4] != ack_seen_q) tx_next_q <= tx_byte_q;
    end
  end

  assign subcode_data_out      = tx_sh_q[7];
  assign subcode_read_clock    = rck_q;
  assign subcode_frame_sync_o  = subcode_frame_sync_o_q;
  assign subcode_frame_sync_oe = subcode_frame_sync_oe_q;

  // ---------------- checks
  AST_IRQ_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    irq_q |-> $past(rx_evt && rx_hold_q[8] && locked_q && sym_q != subcode_pkg::LAST_SYM))
    else $error("sync interrupt without misplaced sync");
  AST_RESYNC: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    rx_evt && rx_hold_q[8] && rx_ctrl_q[subcode_pkg::RX_ENA] |=> locked_q && sym_q == 7'h00)
    else $error("no relock on sync");
  AST_COPY_TRIG: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
    rx_evt && rx_hold_q[8] && rx_ctrl_q[subcode_pkg::RX_ENA] |=> trig_q ##1 !trig_q)
    else $error("copy engine not triggered once on sync");
  AST_COPY_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
    trig_q |-> src_q == subcode_pkg::region_addr(base, {2'b00, bptr_w_q}))
    else $error("copy source outside fifo region");
  AST_DAO_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n) // R20
    dao_valid_q |-> $past(disc_data_mode) && $past(pend_q))
    else $error("digital output subcode outside data mode");
  AST_RCK_IDLE: assert property (@(posedge link_clk) disable iff (!lrst_n) // R12
    st_q == subcode_pkg::LS_IDLE && $past(st_q == subcode_pkg::LS_IDLE) |-> rck_q == $past(cfg_s[1]))
    else $error("read clock idle level wrong");
  AST_PBIT: assert property (@(posedge link_clk) disable iff (!lrst_n) // R16
    slot && st_q == subcode_pkg::LS_IDLE && tx_mode && !cfg_s[6] |=> tx_sh_q[7] == !$past(cfg_s[7]))
    else $error("three-wire P level wrong");
  AST_SUBCODE_FRAME_SYNC_OE: assert property (@(posedge link_clk) disable iff (!lrst_n) // R15
    !cfg_s[5] || cfg_s[2] |=> !subcode_frame_sync_oe_q)
    else $error("sync pin driven while not transmitting");
  AST_SLOT_DIV: assert property (@(posedge link_clk) disable iff (!lrst_n) // R14
    slot |=> div_cnt_q == 3'h0)
    else $error("oversampling divider not restarted");
  COV_IRQ:  cover property (@(posedge sys_clk) disable iff (!rst_n) irq_q);
  COV_TRIG: cover property (@(posedge sys_clk) disable iff (!rst_n) trig_q);
  COV_DAO:  cover property (@(posedge sys_clk) disable iff (!rst_n) dao_valid_q);
endmodule
`default_nettype wire

//--- src/subcode_pkg.sv
`default_nettype none
package subcode_pkg;
  // sub-cpu register addresses
  localparam logic [15:0] A_TX_CTRL  = 16'hff13;
  localparam logic [15:0] A_RX_CTRL  = 16'hff17;
  localparam logic [15:0] A_BASE_H   = 16'hff28;
  localparam logic [15:0] A_BASE_L   = 16'hff29;
  localparam logic [15:0] A_PTR_R_H  = 16'hff2a;
  localparam logic [15:0] A_PTR_R_L  = 16'hff2b;
  localparam logic [15:0] A_BPTR_R_H = 16'hff2c;
  localparam logic [15:0] A_BPTR_R_L = 16'hff2d;
  localparam logic [15:0] A_PTR_W_H  = 16'hff2e;
  localparam logic [15:0] A_PTR_W_L  = 16'hff2f;
  localparam logic [15:0] A_BPTR_W_H = 16'hff30;
  localparam logic [15:0] A_BPTR_W_L = 16'hff31;
  // control bit positions
  localparam int TX_PBIT = 4;
  localparam int TX_ENA  = 2;
  localparam int TX_FMT  = 0;
  localparam int RX_DIV  = 3;
  localparam int RX_ENA  = 2;
  localparam int RX_INV  = 1;
  localparam int RX_FMT  = 0;
  // writable bits and values after reset
  localparam logic [7:0]  TX_CTRL_MASK = 8'h15;
  localparam logic [7:0]  RX_CTRL_MASK = 8'h1f;
  localparam logic [7:0]  BASE_H_MASK  = 8'h1f;
  localparam logic [7:0]  TX_CTRL_RST  = 8'h00;
  localparam logic [7:0]  RX_CTRL_RST  = 8'h00;
  localparam logic [7:0]  BASE_RST     = 8'h00;
  // fifo geometry and placement inside the region
  localparam int          PTR_W          = 9;
  localparam int          FIFO_DEPTH     = 512;
  localparam logic [10:0] RX_FIFO_OFS    = 11'h000;
  localparam logic [10:0] TX_FIFO_OFS    = 11'h200;
  localparam logic [10:0] AUDIO_FIFO_OFS = 11'h400;
  // subcode frame shape
  localparam logic [6:0]  LAST_SYM = 7'h61;
  localparam logic [3:0]  BITS_QW  = 4'h7;
  localparam logic [3:0]  BITS_3W  = 4'h8;

  typedef enum logic [1:0] {LS_IDLE = 2'b01, LS_SHIFT = 2'b10} link_st_e;

  // byte address in external ram: segment base (2 kbyte segments) plus offset
  function automatic logic [23:0] region_addr(input logic [12:0] base, input logic [10:0] ofs);
    return {base, 11'h000} + {13'h0000, ofs};
  endfunction

  // last word-select count of a symbol slot for 1x/2x/4x/8x oversampling
  function automatic logic [2:0] div_last(input logic [1:0] sel);
    return 3'((4'h1 << sel) - 4'h1);
  endfunction
endpackage
`default_nettype wire

//--- src/subcode_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module subcode_sync2 #(
  parameter int W = 1
) (
  // destination clock and its reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level to resynchronise
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] q_q;

  // two stages, the first is read by nothing but the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q_q    <= '0;
    end else begin
      meta_q <= d;
      q_q    <= meta_q;
    end
  end
  assign q = q_q;
endmodule
`default_nettype wire

//--- src/subcode_byte_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module subcode_byte_fifo (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // fill side
  input  wire logic                          wr_en,
  input  wire logic [7:0]                    wr_data,
  output logic                               full,
  // drain side
  input  wire logic                          rd_en,
  output logic      [7:0]                    rd_data,
  output logic                               empty,
  // pointers for software
  output logic      [subcode_pkg::PTR_W-1:0] wr_ptr,
  output logic      [subcode_pkg::PTR_W-1:0] rd_ptr
);
  logic [7:0]                    mem [subcode_pkg::FIFO_DEPTH];
  logic [subcode_pkg::PTR_W-1:0] wr_ptr_q;
  logic [subcode_pkg::PTR_W-1:0] rd_ptr_q;
  logic [subcode_pkg::PTR_W:0]   count_q;
  logic [7:0]                    rd_data_q;
  logic                          do_wr;
  logic                          do_rd;

  assign full  = count_q == 10'h200;
  assign empty = count_q == 10'h000;
  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && !empty;

  // storage, no reset needed on the array
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_q] <= wr_data;
    end
  end

  // 9-bit pointers roll over naturally at 512
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      count_q   <= '0;
      rd_data_q <= 8'h00;
    end else begin
      if (do_wr) wr_ptr_q <= wr_ptr_q + 9'h001; // R23 R24
      if (do_rd) begin
        rd_ptr_q  <= rd_ptr_q + 9'h001; // R23 R24
        rd_data_q <= mem[rd_ptr_q];
      end
      count_q <= count_q + {9'h000, do_wr} - {9'h000, do_rd};
    end
  end

  assign rd_data = rd_data_q;
  assign wr_ptr  = wr_ptr_q;
  assign rd_ptr  = rd_ptr_q;

  AST_PTR_WRAP: assert property (@(posedge clk) disable iff (!rst_n) // R24
    do_wr && wr_ptr_q == 9'h1ff |=> wr_ptr_q == 9'h000)
    else $error("write pointer did not wrap to zero");
endmodule
`default_nettype wire

//--- bench/subcode_dsp_model.sv
`timescale 1ns/10ps
`default_nettype none
module subcode_dsp_model (
  // link clock and pins towards the device
  input  wire logic link_clk,
  output logic      input_word_select,
  output logic      subcode_data_in,
  output logic      subcode_frame_sync_i
);
  localparam int FRAME = 5;
  logic [4:0] cnt_q = 5'h00;
  int         sym_q = 0;
  // symbol moves late in the slot, after every sampled bit
  always @(posedge link_clk) begin
    cnt_q <= cnt_q + 5'h01;
    if (cnt_q == 5'h1e) begin
      // short frame puts the next sync where none is due
      sym_q <= (sym_q == FRAME - 1) ? 0 : sym_q + 1;
    end
  end
  assign input_word_select = ~cnt_q[4];
  assign subcode_frame_sync_i = (sym_q == 0);
  // bits within a symbol differ so the shift order shows in the byte
  assign subcode_data_in = sym_q[1] ^ cnt_q[3];
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  // bench-driven inputs
  logic        sys_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic        cpu_wr = 1'b0, cpu_rd = 1'b0, rx_pop = 1'b0, tx_push = 1'b0, copy_done = 1'b0;
  logic        disc_data_mode = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0]  cpu_wdata = 8'h00;
  // partner pins and design outputs
  logic        input_word_select, subcode_data_in, subcode_frame_sync_i, subcode_data_out;
  logic        subcode_read_clock, subcode_frame_sync_o, subcode_frame_sync_oe, copy_trigger;
  logic        rx_empty, tx_full, crc_syndrome_req, unexpected_sync_irq, dao_sub_valid;
  logic [7:0]  cpu_rdata, rx_pop_data, dao_sub_data;
  logic [23:0] copy_src_addr, audio_fifo_addr;
  wire         output_word_select = input_word_select;
  wire  [7:0]  tx_push_data = cpu_wdata;
  wire  [2:0]  ev = {unexpected_sync_irq, copy_trigger, dao_sub_valid};
  int          mismatches = 0, compares = 0;
  // address, value written, value read back
  logic [31:0] rows [6] = '{32'hff17_ff1f, 32'hff13_ff15, 32'hff28_ff1f, 32'hff29_a5a5, 32'hff2f_5500, 32'hff50_7700};
  always #4 sys_clk = ~sys_clk;
  // period unrelated to the system clock
  always #62.5 link_clk = ~link_clk;
  subcode_dsp_model dsp (.*);
  subcode_serial_interface DUT (.*);
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // k: 0 write, 1 register read, 2 receive pop, 3 copy done
  task automatic acc(input int k, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    {cpu_wr, cpu_rd, rx_pop, copy_done} <= 4'b1000 >> k;
    @(posedge sys_clk);
    {cpu_wr, cpu_rd, rx_pop, copy_done} <= 4'b0000;
    #1;
    if (k == 1 || k == 2) begin
      chk("read data", 24'(d), 24'(k == 2 ? rx_pop_data : cpu_rdata));
    end
  endtask
  // bounded wait on a design pulse
  task automatic wt(input string n, input int b, input int c);
    for (int i = 0; i < c && ev[b] !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    chk(n, 24'h000001, 24'(ev[b]));
  endtask
  task automatic complete_run;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
  initial begin
    // long reset so the link side sees edges too
    repeat (48) @(posedge sys_clk);
    chk("oe in reset", 24'h0, 24'(subcode_frame_sync_oe));
    rst_n <= 1'b1;
    acc(1, subcode_pkg::A_TX_CTRL, subcode_pkg::TX_CTRL_RST);
    foreach (rows[i]) begin
      acc(0, rows[i][31:16], rows[i][15:8]);
      acc(1, rows[i][31:16], rows[i][7:0]);
    end
    chk("audio addr", {13'h1fa5, 11'h400}, audio_fifo_addr);
    acc(0, 16'hff13, 8'h00);
    acc(0, 16'hff17, 8'h02);
    repeat (80) @(posedge sys_clk);
    tx_push <= 1'b1;
    chk("rck idle", 24'h1, 24'(subcode_read_clock));
    // transmitter off, so nothing drains while filling
    repeat (512) @(posedge sys_clk);
    tx_push <= 1'b0;
    disc_data_mode <= 1'b1;
    #1;
    chk("tx full", 24'h1, 24'(tx_full));
    acc(0, 16'hff17, 8'h00);
    acc(0, 16'hff13, 8'h05);
    wt("dao valid", 0, 3000);
    chk("dao data", 24'h000002, 24'(dao_sub_data));
    chk("sync out", 24'h1, 24'(subcode_frame_sync_o));
    chk("sync oe", 24'h1, 24'(subcode_frame_sync_oe));
    // three-wire with P low for a slot, then receive takes the shared pins
    acc(0, 16'hff13, 8'h14);
    repeat (700) @(posedge sys_clk);
    acc(0, 16'hff17, 8'h0e);
    wt("copy trigger", 1, 7000);
    chk("copy addr", {13'h1fa5, 11'h000}, copy_src_addr);
    chk("sync oe off", 24'h0, 24'(subcode_frame_sync_oe));
    acc(3, 16'h0000, 8'h00);
    chk("crc req", 24'h1, 24'(crc_syndrome_req));
    wt("sync irq", 2, 6000);
    chk("rx empty", 24'h0, 24'(rx_empty));
    // 2x oversampling skips every other model symbol
    acc(2, 16'h0000, 8'h1e);
    acc(2, 16'h0000, 8'he1);
    complete_run();
  end
endmodule
`default_nettype wire
